// ===== rtl/slaf_pkg.sv
package slaf_pkg;

    // ------------------------------------------------------------------
    // Operating modes, line classes and transmit signals
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SLAF_MODE_EXCH, SLAF_MODE_NT, SLAF_MODE_SUB} slaf_mode_t;
    typedef enum logic [1:0] {SLAF_RX_NONE, SLAF_RX_FRAME_A0, SLAF_RX_FRAME_A1, SLAF_RX_OTHER} slaf_rx_t;
    typedef enum logic [2:0] {
        SLAF_TX_INFO0, SLAF_TX_INFO1, SLAF_TX_INFO2, SLAF_TX_INFO3, SLAF_TX_INFO4,
        SLAF_TX_SINGLE, SLAF_TX_CONT
    } slaf_tx_t;

    // ------------------------------------------------------------------
    // Command codes, controller to transceiver
    // ------------------------------------------------------------------
    localparam logic [3:0] SLAF_CMD_DEACT_REQ   = 4'h0;
    localparam logic [3:0] SLAF_CMD_RESET       = 4'h1;
    localparam logic [3:0] SLAF_CMD_SINGLE      = 4'h2;
    localparam logic [3:0] SLAF_CMD_CONT        = 4'h3;
    localparam logic [3:0] SLAF_CMD_LOST_SYNC   = 4'h4;
    localparam logic [3:0] SLAF_CMD_ACT_REQ     = 4'h8;
    localparam logic [3:0] SLAF_CMD_ACT_REQ_P10 = 4'h9;
    localparam logic [3:0] SLAF_CMD_ACT_LOOP    = 4'hA;
    localparam logic [3:0] SLAF_CMD_SWITCH      = 4'hC;
    localparam logic [3:0] SLAF_CMD_LOOP_ACT    = 4'hE;
    localparam logic [3:0] SLAF_CMD_DEACT_CONF  = 4'hF;

    // ------------------------------------------------------------------
    // Indication codes, transceiver to controller
    // ------------------------------------------------------------------
    localparam logic [3:0] SLAF_IND_CLK_NEEDED = 4'h0;
    localparam logic [3:0] SLAF_IND_LOST_SYNC  = 4'h4;
    localparam logic [3:0] SLAF_IND_ACT_REQ    = 4'h8;
    localparam logic [3:0] SLAF_IND_CODE_VIOL  = 4'hB;
    localparam logic [3:0] SLAF_IND_ACTIVE     = 4'hC;
    localparam logic [3:0] SLAF_IND_LOOP_ACT   = 4'hE;
    localparam logic [3:0] SLAF_IND_DEACT_DONE = 4'hF;

    // ------------------------------------------------------------------
    // Line pattern and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] SLAF_INFO1_PAT   = 8'h3F;
    localparam int         SLAF_CLK_HZ      = 125_000_000;
    localparam int         SLAF_BIT_HZ      = 192_000;
    localparam int         SLAF_BIT_CYCLES  = SLAF_CLK_HZ / SLAF_BIT_HZ;
    localparam int         SLAF_FRAME_BITS  = 48;
    localparam int         SLAF_SILENCE_MS  = 16;
    localparam int         SLAF_DEACT_MS    = 32;
    localparam int         SLAF_SILENCE_CYC = SLAF_CLK_HZ / 1000 * SLAF_SILENCE_MS;
    localparam int         SLAF_DEACT_CYC   = SLAF_CLK_HZ / 1000 * SLAF_DEACT_MS;
    localparam int         SLAF_ACT_TMO_MS  = 100;
    localparam int         SLAF_ACT_TMO_CYC = SLAF_CLK_HZ / 1000 * SLAF_ACT_TMO_MS;
    localparam int         SLAF_TMR_W       = 22;
    localparam int         SLAF_TMO_W       = 24;

endpackage

// ===== rtl/slaf_if.sv
`timescale 1ns/10ps
interface slaf_if;
    logic [3:0] cmd;
    logic [3:0] ind;

    modport dev (input cmd, output ind);
    modport ctl (output cmd, input ind);
endinterface

// ===== rtl/slaf_dev.sv
`timescale 1ns/10ps
module slaf_dev #(
    parameter int SILENCE_CYC = slaf_pkg::SLAF_SILENCE_CYC,
    parameter int DEACT_CYC   = slaf_pkg::SLAF_DEACT_CYC,
    parameter int BIT_CYC     = slaf_pkg::SLAF_BIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    slaf_if.dev             bus,
    input  wire logic [1:0] mode_sel,
    input  wire logic       clock_freeze_bit,
    input  wire logic       code_violation_enable,
    input  wire logic [1:0] rx_class,
    input  wire logic       rx_code_viol,
    output logic [2:0]      tx_info,
    output logic            tx_bit,
    output logic            tx_pos,
    output logic            tx_neg,
    output logic            loop2_closed,
    output logic            bd_transparent,
    output logic            clocks_run
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SLAF_S_DEACT, SLAF_S_RESET, SLAF_S_TEST_SP, SLAF_S_TEST_CP, SLAF_S_NT_DET,
        SLAF_S_PEND_ACT, SLAF_S_WAIT_SW, SLAF_S_ACTIVE, SLAF_S_LOST_FR, SLAF_S_LOST_U,
        SLAF_S_PEND_DEACT, SLAF_S_WAIT_DC, SLAF_S_TE_PEND, SLAF_S_TE_SYNC
    } slaf_state_t;

    typedef struct packed {
        slaf_state_t              st;
        logic [1:0]               rx_meta;
        logic [1:0]               rx_sync;
        logic                     cv_meta;
        logic                     cv_sync;
        logic [slaf_pkg::SLAF_TMR_W-1:0] t16;
        logic [slaf_pkg::SLAF_TMR_W-1:0] t32;
        logic [9:0]               div;
        logic [5:0]               bit_idx;
        logic [2:0]               pat_idx;
        logic                     pol;
        logic [2:0]               tx_info;
        logic                     tx_bit;
        logic                     tx_pos;
        logic                     tx_neg;
        logic [3:0]               ind;
        logic                     loop2;
        logic                     transp;
        logic                     clk_run;
    } slaf_dev_t;

    localparam logic [slaf_pkg::SLAF_TMR_W-1:0] L16  = slaf_pkg::SLAF_TMR_W'(SILENCE_CYC - 1);
    localparam logic [slaf_pkg::SLAF_TMR_W-1:0] L32  = slaf_pkg::SLAF_TMR_W'(DEACT_CYC - 1);
    localparam logic [9:0]                      LBIT = 10'(BIT_CYC - 1);
    localparam logic [5:0]                      LFRM = 6'(slaf_pkg::SLAF_FRAME_BITS - 1);

    slaf_dev_t r;
    slaf_dev_t n;

    slaf_pkg::slaf_mode_t mode;
    slaf_pkg::slaf_rx_t   rx;
    logic                 frame;
    logic                 tick;
    logic                 pulse;
    logic [3:0]           cmd;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        mode  = slaf_pkg::slaf_mode_t'(mode_sel);
        rx    = slaf_pkg::slaf_rx_t'(r.rx_sync);
        cmd   = bus.cmd;
        frame = (rx == slaf_pkg::SLAF_RX_FRAME_A0) || (rx == slaf_pkg::SLAF_RX_FRAME_A1);
        tick  = (r.div == LBIT);
        pulse = 1'b0;
        n = r;
        n.rx_meta = rx_class;
        n.rx_sync = r.rx_meta;
        n.cv_meta = rx_code_viol;
        n.cv_sync = r.cv_meta;

        // Line bit and frame timing for the pattern and the test pulses.
        n.div = tick ? 10'h000 : r.div + 10'h001;
        if (tick) begin
            n.pat_idx = r.pat_idx + 3'h1;
            n.bit_idx = (r.bit_idx == LFRM) ? 6'h00 : r.bit_idx + 6'h01;
            if (r.st == SLAF_S_TEST_CP || (r.st == SLAF_S_TEST_SP && r.bit_idx == LFRM)) begin
                n.pol = ~r.pol;
            end
        end

        if (cmd == slaf_pkg::SLAF_CMD_RESET) begin
            n.st = SLAF_S_RESET;
        end else if (cmd == slaf_pkg::SLAF_CMD_SINGLE) begin
            if (r.st != SLAF_S_TEST_CP) n.st = SLAF_S_TEST_SP;
        end else if (cmd == slaf_pkg::SLAF_CMD_CONT) begin
            if (r.st != SLAF_S_TEST_SP) n.st = SLAF_S_TEST_CP;
        end else if (mode != slaf_pkg::SLAF_MODE_SUB && cmd == slaf_pkg::SLAF_CMD_DEACT_REQ
                     && r.st != SLAF_S_DEACT && r.st != SLAF_S_PEND_DEACT && r.st != SLAF_S_WAIT_DC) begin
            n.st  = SLAF_S_PEND_DEACT;
            n.t16 = '0;
            n.t32 = '0;
        end else begin
            unique case (r.st)
                SLAF_S_RESET, SLAF_S_TEST_SP, SLAF_S_TEST_CP: begin
                    n.st = SLAF_S_DEACT;
                end
                SLAF_S_DEACT: begin
                    if (mode == slaf_pkg::SLAF_MODE_SUB) begin
                        if (cmd == slaf_pkg::SLAF_CMD_ACT_REQ || cmd == slaf_pkg::SLAF_CMD_ACT_REQ_P10
                            || cmd == slaf_pkg::SLAF_CMD_ACT_LOOP) n.st = SLAF_S_TE_PEND;
                    end else if (cmd == slaf_pkg::SLAF_CMD_ACT_REQ || cmd == slaf_pkg::SLAF_CMD_ACT_LOOP) begin
                        n.st = SLAF_S_PEND_ACT;
                    end else if (rx != slaf_pkg::SLAF_RX_NONE) begin
                        n.st = (mode == slaf_pkg::SLAF_MODE_NT) ? SLAF_S_NT_DET : SLAF_S_PEND_ACT;
                    end
                end
                SLAF_S_NT_DET: begin
                    if (cmd == slaf_pkg::SLAF_CMD_ACT_REQ || cmd == slaf_pkg::SLAF_CMD_ACT_LOOP) begin
                        n.st = SLAF_S_PEND_ACT;
                    end
                end
                SLAF_S_PEND_ACT: begin
                    if (frame) n.st = (mode == slaf_pkg::SLAF_MODE_NT) ? SLAF_S_WAIT_SW : SLAF_S_ACTIVE;
                end
                SLAF_S_WAIT_SW, SLAF_S_LOST_U: begin
                    if (cmd == slaf_pkg::SLAF_CMD_SWITCH || cmd == slaf_pkg::SLAF_CMD_LOOP_ACT) begin
                        n.st = SLAF_S_ACTIVE;
                    end
                end
                SLAF_S_ACTIVE: begin
                    if (!frame) begin
                        n.st = SLAF_S_LOST_FR;
                    end else if (mode == slaf_pkg::SLAF_MODE_NT && cmd == slaf_pkg::SLAF_CMD_LOST_SYNC) begin
                        n.st = SLAF_S_LOST_U;
                    end
                end
                SLAF_S_LOST_FR: begin
                    if (frame) n.st = (mode == slaf_pkg::SLAF_MODE_NT) ? SLAF_S_WAIT_SW : SLAF_S_ACTIVE;
                end
                SLAF_S_PEND_DEACT: begin
                    n.t16 = (rx == slaf_pkg::SLAF_RX_NONE) ? r.t16 + 1'b1 : '0;
                    n.t32 = r.t32 + 1'b1;
                    if ((rx == slaf_pkg::SLAF_RX_NONE && r.t16 == L16) || r.t32 == L32) begin
                        n.st = SLAF_S_WAIT_DC;
                    end
                end
                SLAF_S_WAIT_DC: begin
                    if (cmd == slaf_pkg::SLAF_CMD_DEACT_CONF) n.st = SLAF_S_DEACT;
                end
                SLAF_S_TE_PEND: begin
                    if (frame) n.st = SLAF_S_TE_SYNC;
                end
                SLAF_S_TE_SYNC: begin
                    if (rx == slaf_pkg::SLAF_RX_NONE) n.st = SLAF_S_DEACT;
                end
                default: n.st = SLAF_S_DEACT;
            endcase
        end

        // Outputs follow the next state so that every port is a flip-flop.
        n.ind     = slaf_pkg::SLAF_IND_CLK_NEEDED;
        n.tx_info = slaf_pkg::SLAF_TX_INFO0;
        n.transp  = 1'b0;
        n.clk_run = 1'b1;
        unique case (n.st)
            SLAF_S_DEACT: begin
                n.clk_run = ~clock_freeze_bit;
                if (mode == slaf_pkg::SLAF_MODE_SUB) n.ind = slaf_pkg::SLAF_IND_DEACT_DONE;
            end
            SLAF_S_NT_DET: n.ind = slaf_pkg::SLAF_IND_ACT_REQ;
            SLAF_S_PEND_ACT, SLAF_S_WAIT_SW: begin
                n.tx_info = slaf_pkg::SLAF_TX_INFO2;
                n.ind     = slaf_pkg::SLAF_IND_ACT_REQ;
            end
            SLAF_S_ACTIVE: begin
                n.tx_info = slaf_pkg::SLAF_TX_INFO4;
                n.transp  = 1'b1;
                n.ind     = slaf_pkg::SLAF_IND_ACTIVE;
            end
            SLAF_S_LOST_FR, SLAF_S_LOST_U: begin
                n.tx_info = slaf_pkg::SLAF_TX_INFO2;
                n.ind     = slaf_pkg::SLAF_IND_LOST_SYNC;
            end
            SLAF_S_WAIT_DC: n.ind = slaf_pkg::SLAF_IND_DEACT_DONE;
            SLAF_S_TEST_SP: begin
                n.tx_info = slaf_pkg::SLAF_TX_SINGLE;
                pulse     = (n.bit_idx == 6'h00);
            end
            SLAF_S_TEST_CP: begin
                n.tx_info = slaf_pkg::SLAF_TX_CONT;
                pulse     = 1'b1;
            end
            SLAF_S_TE_PEND: n.tx_info = slaf_pkg::SLAF_TX_INFO1;
            SLAF_S_TE_SYNC: begin
                n.tx_info = slaf_pkg::SLAF_TX_INFO3;
                n.ind     = (rx == slaf_pkg::SLAF_RX_FRAME_A1) ? slaf_pkg::SLAF_IND_ACTIVE
                                                               : slaf_pkg::SLAF_IND_ACT_REQ;
            end
            default: n.ind = slaf_pkg::SLAF_IND_CLK_NEEDED;
        endcase
        if (n.st == SLAF_S_ACTIVE && r.cv_sync && code_violation_enable) begin
            n.ind = slaf_pkg::SLAF_IND_CODE_VIOL;
        end

        // Loop 2 stays closed only through the activation states.
        if (n.st == SLAF_S_PEND_ACT || n.st == SLAF_S_WAIT_SW || n.st == SLAF_S_ACTIVE
            || n.st == SLAF_S_LOST_FR || n.st == SLAF_S_LOST_U) begin
            n.loop2 = r.loop2 || cmd == slaf_pkg::SLAF_CMD_ACT_LOOP
                      || (mode == slaf_pkg::SLAF_MODE_NT && cmd == slaf_pkg::SLAF_CMD_LOOP_ACT);
        end else begin
            n.loop2 = 1'b0;
        end
        if (n.st == SLAF_S_ACTIVE && n.loop2 && mode == slaf_pkg::SLAF_MODE_SUB) begin
            n.ind = slaf_pkg::SLAF_IND_LOOP_ACT;
        end

        n.tx_bit = (n.st == SLAF_S_TE_PEND) && slaf_pkg::SLAF_INFO1_PAT[3'h7 - n.pat_idx];
        n.tx_pos = pulse && n.pol;
        n.tx_neg = pulse && !n.pol;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            r.st      <= SLAF_S_DEACT;
            r.clk_run <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus.ind        = r.ind;
    assign tx_info        = r.tx_info;
    assign tx_bit         = r.tx_bit;
    assign tx_pos         = r.tx_pos;
    assign tx_neg         = r.tx_neg;
    assign loop2_closed   = r.loop2;
    assign bd_transparent = r.transp;
    assign clocks_run     = r.clk_run;

endmodule // slaf_dev

// ===== rtl/slaf_ctl.sv
`timescale 1ns/10ps
module slaf_ctl #(
    parameter int ACT_TMO_CYC = slaf_pkg::SLAF_ACT_TMO_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    slaf_if.ctl             bus,
    input  wire logic [3:0] user_cmd,
    input  wire logic       user_load,
    input  wire logic       auto_confirm,
    output logic [3:0]      cmd_now,
    output logic [3:0]      ind_now,
    output logic            ind_event,
    output logic            act_timeout,
    output logic            busy
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]                      cmd;
        logic [3:0]                      pend;
        logic                            gap;
        logic [slaf_pkg::SLAF_TMO_W-1:0] tmo;
        logic                            tmo_run;
        logic                            tmo_hit;
        logic [3:0]                      ind;
        logic                            ind_evt;
    } slaf_ctl_t;

    localparam logic [slaf_pkg::SLAF_TMO_W-1:0] LTMO = slaf_pkg::SLAF_TMO_W'(ACT_TMO_CYC - 1);

    slaf_ctl_t r;
    slaf_ctl_t n;
    logic      swap;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n         = r;
        n.ind     = bus.ind;
        n.ind_evt = (bus.ind != r.ind);
        n.tmo_hit = 1'b0;
        swap = (r.cmd == slaf_pkg::SLAF_CMD_SINGLE && user_cmd == slaf_pkg::SLAF_CMD_CONT)
            || (r.cmd == slaf_pkg::SLAF_CMD_CONT && user_cmd == slaf_pkg::SLAF_CMD_SINGLE);

        // A code stays on the channel until another one is loaded or auto_confirm sends the confirmation.
        if (user_load) begin
            if (swap) begin
                n.cmd  = slaf_pkg::SLAF_CMD_DEACT_REQ;
                n.pend = user_cmd;
                n.gap  = 1'b1;
            end else begin
                n.cmd = user_cmd;
                n.gap = 1'b0;
            end
        end else if (r.gap) begin
            n.cmd = r.pend;
            n.gap = 1'b0;
        end else if (auto_confirm && bus.ind == slaf_pkg::SLAF_IND_DEACT_DONE) begin
            n.cmd = slaf_pkg::SLAF_CMD_DEACT_CONF;
        end

        // Supervision of the activation, which the transceiver does not time.
        if (n.cmd == slaf_pkg::SLAF_CMD_ACT_REQ && r.cmd != slaf_pkg::SLAF_CMD_ACT_REQ) begin
            n.tmo_run = 1'b1;
            n.tmo     = '0;
        end else if (r.tmo_run) begin
            if (bus.ind == slaf_pkg::SLAF_IND_ACTIVE || n.cmd != slaf_pkg::SLAF_CMD_ACT_REQ) begin
                n.tmo_run = 1'b0;
            end else if (r.tmo == LTMO) begin
                n.tmo_run = 1'b0;
                n.tmo_hit = 1'b1;
            end else begin
                n.tmo = r.tmo + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r     <= '0;
            r.cmd <= slaf_pkg::SLAF_CMD_DEACT_CONF;
            r.ind <= slaf_pkg::SLAF_IND_CLK_NEEDED;
        end else begin
            r <= n;
        end
    end

    assign bus.cmd     = r.cmd;
    assign cmd_now     = r.cmd;
    assign ind_now     = r.ind;
    assign ind_event   = r.ind_evt;
    assign act_timeout = r.tmo_hit;
    assign busy        = r.gap;

endmodule // slaf_ctl

// ===== tb/slaf_sva.sv
`timescale 1ns/10ps
module slaf_sva #(
    parameter int DEACT_CYC = 40
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] cmd,
    input wire logic [3:0] ind,
    input wire logic [1:0] mode_sel
);
    localparam int DEACT_LIM = DEACT_CYC + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ind_legal: assert property (ind inside {4'h0, 4'h4, 4'h8, 4'hB, 4'hC, 4'hE, 4'hF})
        else $error("indication code outside the defined set");
    a_no_test_swap: assert property (cmd inside {4'h2, 4'h3} |=> cmd != ($past(cmd) ^ 4'h1))
        else $error("test codes swapped without a gap");
    a_act_req_ind: assert property (mode_sel == 2'h0 && cmd inside {4'h8, 4'hA} && $past(cmd) == 4'hF && ind == 4'h0 |=> ind == 4'h8)
        else $error("activation command not answered");
    a_active_hold: assert property (mode_sel == 2'h0 && ind == 4'hC && cmd == 4'h8 |=> ind inside {4'hC, 4'hB, 4'h4})
        else $error("activated state left without cause");
    a_deact_info0: assert property (mode_sel != 2'h2 && ind == 4'hC && cmd == 4'h0 |=> ind == 4'h0)
        else $error("deactivation request not taken");
    a_deact_timer: assert property (mode_sel != 2'h2 && $past(ind) != 4'h0 && ind == 4'h0 && cmd == 4'h0 |-> ##[1:DEACT_LIM] ind == 4'hF)
        else $error("deactivation indication late");
    a_confirm_idle: assert property (mode_sel != 2'h2 && ind == 4'hF && cmd == 4'hF |=> ind == 4'h0)
        else $error("confirmation did not reach idle");
    a_idle_stays: assert property (mode_sel == 2'h0 && ind == 4'h0 && cmd == 4'hF && $past(ind) == 4'h0 && $past(cmd) == 4'hF |=> ind inside {4'h0, 4'h8})
        else $error("idle left other than by activation");
    c_active: cover property (ind == 4'hC);
    c_viol: cover property (ind == 4'hB);
    c_confirm: cover property (ind == 4'hF ##1 ind == 4'h0);
endmodule // slaf_sva

// ===== tb/st_layer1_activation_fsm_tb_top.sv
`timescale 1ns/10ps
module st_layer1_activation_fsm_tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic       frz = 1'b1;
    logic       cve = 1'b0;
    logic [1:0] rx_class = 2'h0;
    logic       rx_cv = 1'b0;
    logic [3:0] user_cmd = 4'hF;
    logic       user_load = 1'b0;
    logic       auto_confirm = 1'b0;
    logic [2:0] tx_info;
    logic       loop2, bd, clk_run;
    logic [3:0] cmd_now;
    logic       tbit;
    logic       tpos;
    logic       act_to;
    int         miscompares = 0;
    int         samples_checked = 0;
    slaf_if u_if();
    slaf_dev #(.SILENCE_CYC(20), .DEACT_CYC(40), .BIT_CYC(4)) u_slaf_dev (.clk(clk), .rst_n(rst_n), .bus(u_if),
        .mode_sel(mode_sel), .clock_freeze_bit(frz), .code_violation_enable(cve), .rx_class(rx_class),
        .rx_code_viol(rx_cv), .tx_info(tx_info), .tx_bit(tbit), .tx_pos(tpos), .tx_neg(), .loop2_closed(loop2),
        .bd_transparent(bd), .clocks_run(clk_run));
    slaf_ctl #(.ACT_TMO_CYC(50)) u_slaf_ctl (.clk(clk), .rst_n(rst_n), .bus(u_if), .user_cmd(user_cmd),
        .user_load(user_load), .auto_confirm(auto_confirm), .cmd_now(cmd_now), .ind_now(), .ind_event(),
        .act_timeout(act_to), .busy());
    slaf_sva #(.DEACT_CYC(40)) u_slaf_sva (.clk(clk), .rst_n(rst_n), .cmd(u_if.cmd), .ind(u_if.ind),
        .mode_sel(mode_sel));
    always #4 clk = ~clk;
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [3:0] c);
        @(posedge clk);
        user_cmd <= c;
        user_load <= 1'b1;
        @(posedge clk);
        user_load <= 1'b0;
    endtask
    task automatic line(input logic [1:0] c);
        @(posedge clk);
        rx_class <= c;
    endtask
    task automatic wait_ind(input logic [3:0] code, input int bound, output int n);
        n = 0;
        while (u_if.ind !== code && n < bound) begin
            tick(1);
            n++;
        end
        chk(u_if.ind, code);
        if (u_if.ind !== code) print_verdict();
    endtask
    // ----------------------------------------------------------------
    // Deactivation with the line held at c; the indication must land in lo..hi cycles.
    // ----------------------------------------------------------------
    task automatic s_deact(input logic [1:0] c, input int lo, input int hi);
        int n;
        line(c);
        auto_confirm <= (c == 2'h0);
        send(slaf_pkg::SLAF_CMD_DEACT_REQ);
        wait_ind(slaf_pkg::SLAF_IND_CLK_NEEDED, 4, n);
        chk({1'b0, tx_info}, 4'h0);
        wait_ind(slaf_pkg::SLAF_IND_DEACT_DONE, 60, n);
        chk({3'h0, n >= lo && n <= hi}, 4'h1);
        line(2'h0);
        tick(3);
        send(slaf_pkg::SLAF_CMD_DEACT_CONF);
        wait_ind(slaf_pkg::SLAF_IND_CLK_NEEDED, 6, n);
        chk(cmd_now, 4'hF);
    endtask
    task automatic s_exch();
        int n;
        chk({3'h0, clk_run}, 4'h0);
        chk({1'b0, tx_info}, 4'h0);
        send(slaf_pkg::SLAF_CMD_ACT_REQ);
        wait_ind(slaf_pkg::SLAF_IND_ACT_REQ, 4, n);
        chk({1'b0, tx_info}, 4'h2);
        line(2'h2);
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 8, n);
        chk({1'b0, tx_info}, 4'h4);
        chk({3'h0, bd}, 4'h1);
        @(posedge clk) rx_cv <= 1'b1;
        tick(6);
        chk(u_if.ind, slaf_pkg::SLAF_IND_ACTIVE);
        @(posedge clk) cve <= 1'b1;
        wait_ind(slaf_pkg::SLAF_IND_CODE_VIOL, 6, n);
        @(posedge clk) rx_cv <= 1'b0;
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 6, n);
        line(2'h3);
        wait_ind(slaf_pkg::SLAF_IND_LOST_SYNC, 6, n);
        chk({1'b0, tx_info}, 4'h2);
        line(2'h2);
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 6, n);
        chk({1'b0, tx_info}, 4'h4);
        s_deact(2'h3, 38, 42);
        send(slaf_pkg::SLAF_CMD_ACT_LOOP);
        wait_ind(slaf_pkg::SLAF_IND_ACT_REQ, 4, n);
        chk({3'h0, loop2}, 4'h1);
        s_deact(2'h0, 18, 24);
    endtask
    task automatic s_test();
        int n;
        int k;
        send(slaf_pkg::SLAF_CMD_SINGLE);
        tick(3);
        chk({1'b0, tx_info}, 4'h5);
        send(slaf_pkg::SLAF_CMD_CONT);
        tick(4);
        chk({1'b0, tx_info}, 4'h6);
        chk(cmd_now, slaf_pkg::SLAF_CMD_CONT);
        k = 0;
        repeat (8) begin
            tick(1);
            k += tpos;
        end
        chk(4'(k), 4'h4);
        send(slaf_pkg::SLAF_CMD_RESET);
        line(2'h2);
        tick(6);
        chk({1'b0, tx_info}, 4'h0);
        send(slaf_pkg::SLAF_CMD_DEACT_CONF);
        wait_ind(slaf_pkg::SLAF_IND_ACT_REQ, 8, n);
        s_deact(2'h0, 18, 24);
    endtask
    task automatic s_nt();
        int n;
        @(posedge clk) mode_sel <= 2'h1;
        line(2'h2);
        wait_ind(slaf_pkg::SLAF_IND_ACT_REQ, 6, n);
        chk({1'b0, tx_info}, 4'h0);
        send(slaf_pkg::SLAF_CMD_ACT_REQ);
        tick(4);
        chk({1'b0, tx_info}, 4'h2);
        chk(u_if.ind, slaf_pkg::SLAF_IND_ACT_REQ);
        send(slaf_pkg::SLAF_CMD_SWITCH);
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 4, n);
        chk({1'b0, tx_info}, 4'h4);
        chk({3'h0, bd}, 4'h1);
        send(slaf_pkg::SLAF_CMD_LOST_SYNC);
        wait_ind(slaf_pkg::SLAF_IND_LOST_SYNC, 4, n);
        chk({1'b0, tx_info}, 4'h2);
        send(slaf_pkg::SLAF_CMD_SWITCH);
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 4, n);
        line(2'h3);
        wait_ind(slaf_pkg::SLAF_IND_LOST_SYNC, 6, n);
        chk({1'b0, tx_info}, 4'h2);
        s_deact(2'h0, 18, 24);
    endtask
    task automatic s_sub();
        int n;
        int k;
        @(posedge clk) auto_confirm <= 1'b0;
        mode_sel <= 2'h2;
        tick(2);
        chk(u_if.ind, slaf_pkg::SLAF_IND_DEACT_DONE);
        send(slaf_pkg::SLAF_CMD_ACT_REQ);
        tick(2);
        chk({1'b0, tx_info}, 4'h1);
        k = 0;
        repeat (32) begin
            tick(1);
            k += tbit;
        end
        chk(4'(k / 4), 4'h6);
        n = 0;
        while (!act_to && n < 60) begin
            tick(1);
            n++;
        end
        chk({3'h0, act_to}, 4'h1);
        line(2'h1);
        wait_ind(slaf_pkg::SLAF_IND_ACT_REQ, 6, n);
        chk({1'b0, tx_info}, 4'h3);
        line(2'h2);
        wait_ind(slaf_pkg::SLAF_IND_ACTIVE, 6, n);
        line(2'h0);
        wait_ind(slaf_pkg::SLAF_IND_DEACT_DONE, 6, n);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        s_exch();
        s_test();
        s_nt();
        s_sub();
        print_verdict();
    end
endmodule // st_layer1_activation_fsm_tb_top
